// file: src/sps_pkg.sv
// Shared constants, register map and carrier types of the serial peripheral select block.
package sps_pkg;

  // ==========================================================================
  // Register indices as printed; the byte address is four times the index.
  // ==========================================================================
  localparam logic [7:0] IDX_CTRL_A    = 8'h00;
  localparam logic [7:0] IDX_CONTROL_TWO = 8'h04;
  localparam logic [7:0] IDX_BAUD      = 8'h0c;
  localparam logic [7:0] IDX_IRQ_CLR   = 8'h14;
  localparam logic [7:0] IDX_IRQ_SET   = 8'h16;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h18;
  localparam logic [7:0] IDX_STATUS    = 8'h1a;
  localparam logic [7:0] IDX_SYNC_BUSY = 8'h1c;
  localparam logic [7:0] IDX_DATA      = 8'h28;

  localparam logic [9:0] ADDR_CTRL_A      = {IDX_CTRL_A, 2'b00};
  localparam logic [9:0] ADDR_CONTROL_TWO = {IDX_CONTROL_TWO, 2'b00};
  localparam logic [9:0] ADDR_BAUD        = {IDX_BAUD, 2'b00};
  localparam logic [9:0] ADDR_IRQ_CLR     = {IDX_IRQ_CLR, 2'b00};
  localparam logic [9:0] ADDR_IRQ_SET     = {IDX_IRQ_SET, 2'b00};
  localparam logic [9:0] ADDR_IRQ_FLAGS   = {IDX_IRQ_FLAGS, 2'b00};
  localparam logic [9:0] ADDR_STATUS      = {IDX_STATUS, 2'b00};
  localparam logic [9:0] ADDR_SYNC_BUSY   = {IDX_SYNC_BUSY, 2'b00};
  localparam logic [9:0] ADDR_DATA        = {IDX_DATA, 2'b00};

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int CA_SOFT_RESET = 0;
  localparam int CA_ENABLE     = 1;
  localparam int CA_MODE_LO    = 2;
  localparam int CA_RUN_STBY   = 7;
  localparam int CA_DATA_OUT_PINOUT_LO    = 16;
  localparam int CA_DATA_IN_PINOUT_LO    = 20;
  localparam int CA_CPHA       = 28;
  localparam int CA_CPOL       = 29;
  localparam int CB_SELECT_LOW_DETECT_ENABLE       = 9;
  localparam int CB_HWSS       = 13;
  localparam int CB_RECEIVER_ENABLE       = 17;
  localparam int IF_DRE        = 0;
  localparam int IF_TXC        = 1;
  localparam int IF_RXC        = 2;
  localparam int IF_SSL        = 3;
  localparam int IF_ERROR      = 7;
  localparam int ST_OVERFLOW   = 2;
  localparam int SB_SOFT_RESET = 0;
  localparam int SB_ENABLE     = 1;
  localparam int SB_CONTROL_TWO = 2;

  // ==========================================================================
  // Reset values, mode codes and timing counts.
  // ==========================================================================
  localparam logic [2:0] MODE_MASTER   = 3'h3;
  localparam logic [2:0] MODE_SLAVE    = 3'h2;
  localparam logic [7:0] IRQ_MASK_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST      = 8'h00;
  localparam logic [4:0] GUARD_TICKS   = 5'h02;  // Half-baud ticks in one baud cycle.
  localparam logic [4:0] CHAR_TICKS    = 5'h10;  // Half-baud ticks in one 8-bit character.
  localparam int         SYNC_CYCLES   = 3;      // Clock cycles a synchronised write stays busy.

  // ==========================================================================
  // Carrier types.
  // ==========================================================================
  typedef struct packed {
    logic       run_in_standby;
    logic [2:0] mode;
    logic [1:0] data_in_pinout;
    logic [1:0] data_out_pinout;
    logic       cpol;
    logic       cpha;
    logic       hw_select_enable;
    logic       select_low_detect_enable;
  } sps_cfg_t;

  localparam sps_cfg_t CFG_RST = '0;

  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_LEAD  = 3'b001,
    M_XFER  = 3'b011,
    M_TRAIL = 3'b010,
    M_GAP   = 3'b110
  } sps_mstate_t;

endpackage

// file: src/sps_top.sv
// Serial peripheral block with select timing, DMA requests, interrupts, sleep and write synchronisation.
`timescale 1ns/1ps

module sps_top
  import sps_pkg::*;
#(
  parameter int SYNC_CYC = SYNC_CYCLES
) (
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [9:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SCK_IN,
  output logic             SCK_OUT,
  output logic             SCK_OE,
  input  wire logic        SS_IN,
  output logic             SS_OUT,
  output logic             SS_OE,
  input  wire logic [1:0]  DATA_PAD_IN,
  output logic      [1:0]  DATA_PAD_OUT,
  output logic      [1:0]  DATA_PAD_OE,
  input  wire logic        STANDBY,
  output logic             CORE_CLK_ON,
  output logic             WAKE,
  output logic             IRQ,
  output logic             DMA_RX_REQ,
  output logic             DMA_TX_REQ
);

  // ==========================================================================
  // State.
  // ==========================================================================
  sps_cfg_t    cfg;
  logic        enable;
  logic        receiver_enable;
  logic [7:0]  baud;
  logic [7:0]  irq_mask;
  logic [7:0]  sticky;
  logic        overflow_bit;
  logic [2:0]  sync_busy_a;
  logic [2:0]  sync_pend;
  logic        pend_enable;
  logic        pend_receiver_enable;
  logic [3:0]  sync_cnt;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic [7:0]  rx_mem [2];
  logic        rx_wp;
  logic        rx_rp;
  logic [1:0]  rx_cnt;
  logic [7:0]  sreg;
  logic        sreg_full;
  logic        out_bit;
  logic [2:0]  bit_cnt;
  sps_mstate_t mstate;
  logic [7:0]  baud_cnt;
  logic [4:0]  tick_cnt;
  logic        sck_m;
  logic        ss_m;
  logic        rd_nonempty;
  logic [3:0]  meta;
  logic [3:0]  sync_in;
  logic        sck_d;
  logic        ss_d;

  // ==========================================================================
  // Pin synchronisers: two flops; logic reads the second stage, and a third on clock and select for edges.
  // ==========================================================================
  always_ff @(posedge CLOCK) begin
    meta    <= {SCK_IN, SS_IN, DATA_PAD_IN};
    sync_in <= meta;
    sck_d   <= sync_in[3];
    ss_d    <= sync_in[2];
  end

  wire sck_s = sync_in[3];
  wire ss_s  = sync_in[2];

  // ==========================================================================
  // Decode of mode, bus access and register selects.
  // ==========================================================================
  wire is_master   = enable && (cfg.mode == MODE_MASTER);
  wire is_slave    = enable && (cfg.mode == MODE_SLAVE);
  wire acc         = PSEL && PENABLE;
  wire wr          = acc && PWRITE;
  wire rd_setup    = PSEL && !PENABLE && !PWRITE;
  wire sel_ctrl_a  = (PADDR == ADDR_CTRL_A);
  wire sel_ctrl_b  = (PADDR == ADDR_CONTROL_TWO);
  wire sel_baud    = (PADDR == ADDR_BAUD);
  wire sel_clr     = (PADDR == ADDR_IRQ_CLR);
  wire sel_set     = (PADDR == ADDR_IRQ_SET);
  wire sel_flags   = (PADDR == ADDR_IRQ_FLAGS);
  wire sel_status  = (PADDR == ADDR_STATUS);
  wire sel_sync    = (PADDR == ADDR_SYNC_BUSY);
  wire sel_data    = (PADDR == ADDR_DATA);

  // A write to a synchronised register while its busy bit stands is refused.
  wire err_a       = sel_ctrl_a && (sync_busy_a[SB_SOFT_RESET] || sync_busy_a[SB_ENABLE]);
  wire err_b       = sel_ctrl_b && sync_busy_a[SB_CONTROL_TWO];
  wire wr_ok       = wr && !err_a && !err_b;
  wire sync_done   = (sync_pend != 3'b000) && (sync_cnt == 4'h0);
  wire soft_rst    = sync_done && sync_pend[SB_SOFT_RESET];
  wire rst         = SYS_RST || soft_rst;

  assign PREADY  = 1'b1;
  assign PSLVERR = wr && (err_a || err_b);

  // ==========================================================================
  // Sleep: which parts keep their core clock.
  // ==========================================================================
  wire busy_m      = (mstate != M_IDLE);
  wire core_run_m  = !STANDBY || cfg.run_in_standby || busy_m;
  wire core_run_s  = !STANDBY || cfg.run_in_standby;
  wire drop_rx     = is_slave && !core_run_s;
  assign CORE_CLK_ON = is_master ? core_run_m : core_run_s;

  // ==========================================================================
  // Baud divider: one tick per half baud cycle, aligned at transfer start.
  // ==========================================================================
  wire tick       = (baud_cnt == baud);
  wire start_m    = is_master && core_run_m && (mstate == M_IDLE) && (tx_valid || sreg_full);
  wire tick_last  = tick && (tick_cnt == (GUARD_TICKS - 5'h01));
  wire char_end_m = tick && (mstate == M_XFER) && (tick_cnt == (CHAR_TICKS - 5'h01));

  always_ff @(posedge CLOCK) begin
    if (rst || !busy_m || tick) begin
      baud_cnt <= 8'h00;
    end else begin
      baud_cnt <= baud_cnt + 8'h01;
    end
  end

  // ==========================================================================
  // Clock edge events shared by master and slave engines.
  // ==========================================================================
  wire lead_m    = tick && (mstate == M_XFER) && !tick_cnt[0];
  wire trail_m   = tick && (mstate == M_XFER) && tick_cnt[0];
  wire slave_on  = is_slave && !ss_s && !drop_rx;
  wire sck_chg   = slave_on && (sck_s != sck_d);
  wire lead_s    = sck_chg && (sck_s != cfg.cpol);
  wire trail_s   = sck_chg && (sck_s == cfg.cpol);
  wire lead_ev   = lead_m || lead_s;
  wire trail_ev  = trail_m || trail_s;
  wire sample_ev = cfg.cpha ? trail_ev : lead_ev;
  wire setup_ev  = cfg.cpha ? lead_ev : trail_ev;
  wire din       = sync_in[cfg.data_in_pinout[0]];
  wire [7:0] shifted = {sreg[6:0], din};
  wire last_bit  = sample_ev && (bit_cnt == 3'h7);
  wire ss_fall   = is_slave && ss_d && !ss_s;
  wire ss_rise   = is_slave && !ss_d && ss_s;

  // ==========================================================================
  // Master sequencer: lead guard, character, trail guard and gap.
  // ==========================================================================
  sps_mstate_t next_mstate;
  always_comb begin
    next_mstate = mstate;
    unique case (mstate)
      M_IDLE: begin
        if (start_m) begin
          next_mstate = cfg.hw_select_enable ? M_LEAD : M_XFER;
        end
      end
      M_LEAD: begin
        if (tick_last) begin
          next_mstate = M_XFER;
        end
      end
      M_XFER: begin
        if (char_end_m) begin
          if (cfg.hw_select_enable) begin
            next_mstate = M_TRAIL;
          end else if (!sreg_full) begin
            next_mstate = M_IDLE;
          end
        end
      end
      M_TRAIL: begin
        if (tick_last) begin
          next_mstate = M_GAP;
        end
      end
      M_GAP: begin
        if (tick_last) begin
          next_mstate = M_IDLE;
        end
      end
      default: begin
        next_mstate = M_IDLE;
      end
    endcase
  end

  // Tick counter restarts on every state change so each guard lasts two half-baud ticks.
  always_ff @(posedge CLOCK) begin
    if (rst || !is_master) begin
      mstate   <= M_IDLE;
      tick_cnt <= 5'h00;
    end else begin
      mstate <= next_mstate;
      if (next_mstate != mstate || char_end_m) begin
        tick_cnt <= 5'h00;
      end else if (tick) begin
        tick_cnt <= tick_cnt + 5'h01;
      end
    end
  end

  // Master clock toggles on every tick of a character and rests at the idle polarity.
  always_ff @(posedge CLOCK) begin
    if (rst || mstate != M_XFER) begin
      sck_m <= cfg.cpol;
    end else if (tick) begin
      sck_m <= !sck_m;
    end
  end

  // Select is low from the lead guard through the trail guard, high in the gap.
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      ss_m <= 1'b1;
    end else begin
      ss_m <= !((next_mstate == M_LEAD) || (next_mstate == M_XFER) || (next_mstate == M_TRAIL));
    end
  end

  // ==========================================================================
  // Shift register, shared by both roles.
  // ==========================================================================
  wire load_tx = tx_valid && ((start_m && !sreg_full) || last_bit || ss_fall);
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      sreg      <= 8'h00;
      sreg_full <= 1'b0;
      out_bit   <= 1'b0;
      bit_cnt   <= 3'h0;
    end else begin
      if (start_m && !sreg_full) begin
        sreg    <= tx_data;
        out_bit <= tx_data[7];
      end else if (start_m) begin
        out_bit <= sreg[7];
      end else if (ss_fall) begin
        sreg    <= tx_valid ? tx_data : sreg;  // Without new data the shift register is sent as it stands.
        out_bit <= tx_valid ? tx_data[7] : sreg[7];
      end else if (last_bit) begin
        sreg    <= tx_valid ? tx_data : shifted;
      end else if (sample_ev) begin
        sreg    <= shifted;
      end else if (setup_ev) begin
        out_bit <= sreg[7];
      end
      if (start_m) begin
        sreg_full <= 1'b0;
      end else if (last_bit && is_master) begin
        sreg_full <= tx_valid;
      end
      if (ss_fall || start_m || drop_rx) begin
        bit_cnt <= 3'h0;
      end else if (sample_ev) begin
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  // ==========================================================================
  // Transmit buffer: written by software, emptied into the shift register.
  // ==========================================================================
  wire wr_data = wr_ok && sel_data;
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
    end else if (wr_data) begin
      tx_data  <= PWDATA[7:0];
      tx_valid <= 1'b1;
    end else if (load_tx) begin
      tx_valid <= 1'b0;
    end
  end

  // ==========================================================================
  // Two-level receive FIFO with overflow detection.
  // ==========================================================================
  wire push    = last_bit && receiver_enable && !drop_rx;
  wire pop     = acc && !PWRITE && sel_data && rd_nonempty;
  wire rx_full = (rx_cnt == 2'h2);
  wire ovf     = push && rx_full && !pop;

  always_ff @(posedge CLOCK) begin
    if (rst || !receiver_enable) begin
      rx_wp  <= 1'b0;
      rx_rp  <= 1'b0;
      rx_cnt <= 2'h0;
    end else begin
      if (push && !ovf) begin
        rx_mem[rx_wp] <= shifted;
        rx_wp         <= !rx_wp;
      end
      if (pop) begin
        rx_rp <= !rx_rp;
      end
      rx_cnt <= rx_cnt + {1'b0, push && !ovf} - {1'b0, pop};
    end
  end

  // ==========================================================================
  // Interrupt flags; hardware set wins over a software clear in the same cycle.
  // ==========================================================================
  wire [7:0] set_ev = {ovf, 3'b000, ss_fall && cfg.select_low_detect_enable,
                       1'b0, (char_end_m && !sreg_full && !tx_valid) || ss_rise, 1'b0};
  wire [7:0] clr_ev = (wr_ok && sel_flags) ? PWDATA[7:0] : 8'h00;
  wire [7:0] flags  = {sticky[IF_ERROR], 3'b000, sticky[IF_SSL],
                       (rx_cnt != 2'h0), sticky[IF_TXC], !tx_valid};

  always_ff @(posedge CLOCK) begin
    if (rst) begin
      sticky <= 8'h00;
    end else begin
      sticky <= set_ev | (sticky & ~clr_ev);
    end
  end

  // Overflow is sticky, cleared by a one or by turning the receiver off.
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      overflow_bit <= 1'b0;
    end else if (ovf) begin
      overflow_bit <= 1'b1;
    end else if (!receiver_enable || (wr_ok && sel_status && PWDATA[ST_OVERFLOW])) begin
      overflow_bit <= 1'b0;
    end
  end

  // Mask bits change only where a one is written.
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      irq_mask <= IRQ_MASK_RST;
    end else if (wr_ok && sel_set) begin
      irq_mask <= irq_mask | PWDATA[7:0];
    end else if (wr_ok && sel_clr) begin
      irq_mask <= irq_mask & ~PWDATA[7:0];
    end
  end

  assign IRQ        = |(flags & irq_mask);
  assign DMA_RX_REQ = (rx_cnt != 2'h0);
  assign DMA_TX_REQ = !tx_valid;
  wire   wake_m     = IRQ;
  wire   wake_s     = (cfg.run_in_standby && flags[IF_RXC] && irq_mask[IF_RXC]) ||
                      (sticky[IF_SSL] && irq_mask[IF_SSL]);
  assign WAKE       = STANDBY && (is_master ? wake_m : wake_s);

  // ==========================================================================
  // Configuration and write synchronisation of reset, enable and receiver.
  // ==========================================================================
  wire wr_a = wr_ok && sel_ctrl_a;
  wire wr_b = wr_ok && sel_ctrl_b;

  // Other fields are enable-protected: they change only while the block is off.
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      cfg  <= CFG_RST;
      baud <= BAUD_RST;
    end else begin
      if (wr_a && !enable) begin
        cfg.run_in_standby  <= PWDATA[CA_RUN_STBY];
        cfg.mode            <= PWDATA[CA_MODE_LO +: 3];
        cfg.data_out_pinout <= PWDATA[CA_DATA_OUT_PINOUT_LO +: 2];
        cfg.data_in_pinout  <= PWDATA[CA_DATA_IN_PINOUT_LO +: 2];
        cfg.cpha            <= PWDATA[CA_CPHA];
        cfg.cpol            <= PWDATA[CA_CPOL];
      end
      if (wr_b && !enable) begin
        cfg.select_low_detect_enable <= PWDATA[CB_SELECT_LOW_DETECT_ENABLE];
        cfg.hw_select_enable         <= PWDATA[CB_HWSS];
      end
      if (wr_ok && sel_baud && !enable) begin
        baud <= PWDATA[7:0];
      end
    end
  end

  // Busy rises in the cycle after the write and the value lands when the count runs out.
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      sync_pend       <= 3'b000;
      sync_cnt        <= 4'h0;
      pend_enable     <= 1'b0;
      pend_receiver_enable       <= 1'b0;
      enable          <= 1'b0;
      receiver_enable <= 1'b0;
    end else begin
      if (wr_a || wr_b) begin
        sync_pend <= (sync_done ? 3'b000 : sync_pend) | {wr_b, wr_a, wr_a && PWDATA[CA_SOFT_RESET]};
        sync_cnt  <= 4'(SYNC_CYC - 1);
      end else if (sync_done) begin
        sync_pend <= 3'b000;
      end else if (sync_pend != 3'b000) begin
        sync_cnt <= sync_cnt - 4'h1;
      end
      if (wr_a) begin
        pend_enable <= PWDATA[CA_ENABLE];
      end
      if (wr_b) begin
        pend_receiver_enable <= PWDATA[CB_RECEIVER_ENABLE];
      end
      if (sync_done && sync_pend[SB_ENABLE]) begin
        enable <= pend_enable;
      end
      if (sync_done && sync_pend[SB_CONTROL_TWO]) begin
        receiver_enable <= pend_receiver_enable;
      end
    end
  end

  assign sync_busy_a = sync_pend;

  // ==========================================================================
  // Read path: data captured in the setup phase, popped in the access phase.
  // ==========================================================================
  wire [31:0] rd_val =
      sel_ctrl_a ? (32'(cfg.run_in_standby) << CA_RUN_STBY) | (32'(cfg.mode) << CA_MODE_LO) |
                   (32'(enable) << CA_ENABLE) | (32'(cfg.data_out_pinout) << CA_DATA_OUT_PINOUT_LO) |
                   (32'(cfg.data_in_pinout) << CA_DATA_IN_PINOUT_LO) | (32'(cfg.cpha) << CA_CPHA) |
                   (32'(cfg.cpol) << CA_CPOL) :
      sel_ctrl_b ? (32'(cfg.select_low_detect_enable) << CB_SELECT_LOW_DETECT_ENABLE) |
                   (32'(cfg.hw_select_enable) << CB_HWSS) | (32'(receiver_enable) << CB_RECEIVER_ENABLE) :
      sel_baud   ? {24'h000000, baud} :
      (sel_set || sel_clr) ? {24'h000000, irq_mask} :
      sel_flags  ? {24'h000000, flags} :
      sel_status ? (32'(overflow_bit) << ST_OVERFLOW) :
      sel_sync   ? {29'h00000000, sync_busy_a} :
      (sel_data && rx_cnt != 2'h0) ? {24'h000000, rx_mem[rx_rp]} :
      32'h00000000;

  always_ff @(posedge CLOCK) begin
    if (rst) begin
      PRDATA      <= 32'h00000000;
      rd_nonempty <= 1'b0;
    end else if (rd_setup) begin
      PRDATA      <= rd_val;
      rd_nonempty <= sel_data && (rx_cnt != 2'h0);
    end
  end

  // ==========================================================================
  // Pads; with both pinouts on one pad the driven level is read back.
  // ==========================================================================
  wire data_drive = (is_master && busy_m) || slave_on;
  assign SCK_OUT      = sck_m;
  assign SCK_OE       = is_master;
  assign SS_OUT       = ss_m;
  assign SS_OE        = is_master && cfg.hw_select_enable;
  assign DATA_PAD_OUT = {out_bit, out_bit};
  assign DATA_PAD_OE  = {data_drive && cfg.data_out_pinout[0], data_drive && !cfg.data_out_pinout[0]};

endmodule

// file: sim/sps_checker.sv
// Port checker of bus, select, sleep and request behaviour.
`timescale 1ns/1ps
module sps_checker
  import sps_pkg::*;
#(parameter int SYNC_CYC = 3) (
  input wire logic       CLOCK,
  input wire logic       SYS_RST,
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [7:0] PWDATA,
  input wire logic       PSLVERR,
  input wire logic       SCK_OUT,
  input wire logic       SS_OUT,
  input wire logic       STANDBY,
  input wire logic       CORE_CLK_ON,
  input wire logic       WAKE,
  input wire logic       IRQ,
  input wire logic       DMA_RX_REQ,
  input wire logic       DMA_TX_REQ
);
  // ==========================================================================
  // Decodes and assertions; a refused write is only checked when the busy window spans it.
  wire wr_c2  = PSEL && PENABLE && PWRITE && PADDR == ADDR_CONTROL_TWO;
  wire wr_clr = PSEL && PENABLE && PWRITE && PADDR == ADDR_IRQ_CLR && PWDATA == 8'hff;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  err_phase_a: assert property (PSLVERR |-> PSEL && PENABLE && PWRITE) else $error("stray bus error");
  busy_refuse_a: assert property (wr_c2 && !PSLVERR ##3 wr_c2 |-> PSLVERR || SYNC_CYC < 4)
    else $error("busy write accepted");
  reset_state_a: assert property ($fell(SYS_RST) |-> !IRQ && DMA_TX_REQ && !DMA_RX_REQ && SS_OUT)
    else $error("bad state after reset");
  ss_lead_a: assert property ($fell(SS_OUT) |-> !SS_OUT [*2] ##0 $stable(SCK_OUT)) else $error("short lead");
  ss_gap_a: assert property ($rose(SS_OUT) |-> SS_OUT [*2]) else $error("short gap");
  clr_all_a: assert property (wr_clr |=> !IRQ) else $error("irq after disable");
  core_idle_a: assert property (!STANDBY |-> CORE_CLK_ON) else $error("core clock off awake");
  stop_after_a: assert property ($fell(CORE_CLK_ON) |-> SS_OUT) else $error("clock stop mid frame");
  wake_sleep_a: assert property (WAKE |-> STANDBY) else $error("wake while awake");
  cover property (PSLVERR);
  cover property ($rose(SS_OUT));
  cover property ($fell(CORE_CLK_ON));
endmodule

bind sps_top sps_checker #(.SYNC_CYC(SYNC_CYC)) u_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA[7:0]), .PSLVERR(PSLVERR), .SCK_OUT(SCK_OUT),
  .SS_OUT(SS_OUT), .STANDBY(STANDBY), .CORE_CLK_ON(CORE_CLK_ON), .WAKE(WAKE), .IRQ(IRQ),
  .DMA_RX_REQ(DMA_RX_REQ), .DMA_TX_REQ(DMA_TX_REQ));

// file: sim/sps_partner.sv
// Behavioural mode-zero slave on the far side of the master link.
`timescale 1ns/1ps
module sps_partner #(parameter logic [7:0] RESP = 8'h5a) (
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  output logic            miso = 1'b0,
  output logic      [7:0] rx = 8'h00
);
  logic [7:0] sh;
  logic       ss_q = 1'b1;
  // One process owns the reply line: load on select, shift on the falling clock, invert on release.
  always @(ss_n or negedge sck) begin
    ss_q <= ss_n;
    if (ss_n === 1'b0 && ss_q !== 1'b0) begin
      sh   <= RESP;
      miso <= RESP[7];
    end else if (ss_n === 1'b1 && ss_q === 1'b0) begin
      miso <= ~miso;  // A released line shows the inverse of its last bit, so a stale sample is caught.
    end else if (ss_n === 1'b0) begin
      sh   <= {sh[6:0], 1'b0};
      miso <= sh[6];
    end
  end
  // Sample on the rising clock while selected.
  always @(posedge sck) if (!ss_n) rx <= {rx[6:0], mosi};
endmodule

// file: sim/sps_top_test.sv
// Self-checking bench of the select, request, sleep and synchronised-write block.
`timescale 1ns/1ps
module sps_top_test
  import sps_pkg::*;
;
  logic        CLOCK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, STANDBY = 0, ss_drv = 1;
  logic [9:0]  PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA;
  logic        PREADY, PSLVERR, SCK_OUT, SCK_OE, SS_OUT, SS_OE, CORE_CLK_ON, WAKE, IRQ, DMA_RX_REQ, DMA_TX_REQ, miso;
  logic [1:0]  DATA_PAD_OUT, DATA_PAD_OE;
  logic [7:0]  rx, b;
  logic [32:0] exp_q[$], frm_q[$];
  integer      seed = 41, n_errors = 0, num_checks = 0, cyc = 0, i;
  wire         SCK_IN = SCK_OE ? SCK_OUT : 1'b0;
  wire         SS_IN = SS_OE ? SS_OUT : ss_drv;
  wire [1:0]   DATA_PAD_IN = {miso, DATA_PAD_OE[0] ? DATA_PAD_OUT[0] : ~DATA_PAD_OUT[0]};
  sps_top #(.SYNC_CYC(8)) DUT (.*);
  sps_partner part (.sck(SCK_IN), .ss_n(SS_IN), .mosi(DATA_PAD_IN[0]), .miso(miso), .rx(rx));
  always #50 CLOCK = ~CLOCK;
  // ==========================================================================
  // Tasks.
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer; the idle edge first keeps back-to-back calls from driving twice in one step.
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge CLOCK);
    {PSEL, PWRITE, PADDR, PWDATA, PENABLE} <= {1'b1, w, a, d, 1'b0};
    @(posedge CLOCK) PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    {PSEL, PENABLE} <= 2'b00;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Monitors take the oldest note whenever a bus answer or a finished frame shows up.
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (PSEL && PENABLE && PREADY === 1'b1) chk("apb", exp_q.pop_front(), {PSLVERR, PWRITE ? 32'h0 : PRDATA});
    if (cyc == 30000) begin
      n_errors++;
      test_done;
    end
  end
  always @(posedge SS_IN) if (frm_q.size() > 0) chk("frame", frm_q.pop_front(), 33'(rx));
  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (4) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    xfer(0, 10'h3fc, 0, 33'h0);
    xfer(1, ADDR_CONTROL_TWO, 32'h0002_2000, 33'h0);
    xfer(1, ADDR_CONTROL_TWO, 32'h0002_2000, 33'h1_0000_0000);
    xfer(0, ADDR_SYNC_BUSY, 0, 33'h4);
    repeat (8) @(posedge CLOCK);
    xfer(1, ADDR_BAUD, 32'h3, 33'h0);
    xfer(1, ADDR_IRQ_SET, 32'h2, 33'h0);
    xfer(1, ADDR_CTRL_A, 32'h0010_000e, 33'h0);
    repeat (8) @(posedge CLOCK);
    for (i = 0; i < 2; i++) begin
      b = 8'($random(seed));
      frm_q.push_back(33'(b));
      xfer(1, ADDR_DATA, 32'(b), 33'h0);
      @(negedge CLOCK) chk("tx_dma", 33'h0, 33'(DMA_TX_REQ));
    end
    for (i = 0; i < 4000 && IRQ !== 1'b1; i++) @(posedge CLOCK);
    @(negedge CLOCK) chk("rx_dma", 33'h1, 33'(DMA_RX_REQ));
    xfer(0, ADDR_DATA, 0, 33'h5a);
    xfer(0, ADDR_DATA, 0, 33'h5a);
    @(negedge CLOCK) chk("rx_dma", 33'h0, 33'(DMA_RX_REQ));
    xfer(0, ADDR_IRQ_FLAGS, 0, 33'h3);
    xfer(1, ADDR_IRQ_FLAGS, 32'h2, 33'h0);
    @(negedge CLOCK) chk("irq", 33'h0, 33'(IRQ));
    frm_q.push_back(33'h0a5);
    xfer(1, ADDR_DATA, 32'h0a5, 33'h0);
    for (i = 0; i < 400 && SS_IN !== 1'b0; i++) @(posedge CLOCK);
    STANDBY <= 1'b1;
    for (i = 0; i < 400 && CORE_CLK_ON !== 1'b0; i++) @(posedge CLOCK);
    @(negedge CLOCK) chk("select", 33'h1, 33'(SS_IN));
    chk("wake", 33'h1, 33'(WAKE));
    xfer(1, ADDR_IRQ_CLR, 32'hff, 33'h0);
    STANDBY <= 1'b0;
    @(negedge CLOCK) chk("irq", 33'h0, 33'(IRQ));
    // Slave role: a falling select sets the select-low flag, which raises the request and wakes.
    xfer(1, ADDR_CTRL_A, 32'h0, 33'h0);
    repeat (8) @(posedge CLOCK);
    xfer(1, ADDR_CONTROL_TWO, 32'h0002_0200, 33'h0);
    xfer(1, ADDR_CTRL_A, 32'h0000_000a, 33'h0);
    repeat (8) @(posedge CLOCK);
    xfer(1, ADDR_IRQ_SET, 32'h8, 33'h0);
    {STANDBY, ss_drv} <= 2'b10;
    repeat (4) @(posedge CLOCK);
    @(negedge CLOCK) chk("irq", 33'h1, 33'(IRQ));
    chk("wake", 33'h1, 33'(WAKE));
    test_done;
  end
endmodule
